/* File: rtl/sld_regs.svh */
// Register offsets, field positions, reset values and timing figures
`ifndef SLD_REGS_SVH
`define SLD_REGS_SVH
`define SLD_CLK_HZ         20000000
`define SLD_FLICKER_MS     50
`define SLD_BLINK_MS       200
`define SLD_GAP_MS         1000
`define SLD_CTRL_OFS       8'h00
`define SLD_COND_OFS       8'h04
`define SLD_INT_STAT_OFS   8'h08
`define SLD_INT_MASK_OFS   8'h0C
`define SLD_CTRL_TEST_BIT  0
`define SLD_CTRL_RST       1'h0
`define SLD_MASK_RST       4'h0
`define SLD_EV_WDOG        0
`define SLD_EV_PWR         1
`define SLD_EV_BUS         2
`define SLD_EV_NFE         3
`define SLD_COND_RUN_BIT   16
`define SLD_COND_FAULT_BIT 17
`endif

/* File: rtl/sld_pkg.sv */
// Types shared by the status indicator driver modules
package sld_pkg;
	typedef enum logic [2:0] {
		SLD_PAT_OFF     = 3'b000,
		SLD_PAT_ON      = 3'b001,
		SLD_PAT_FLICKER = 3'b010,
		SLD_PAT_BLINK1  = 3'b011,
		SLD_PAT_BLINK2  = 3'b100
	} sld_pat_t;
	typedef enum logic [1:0] {
		SLD_PH_ON1  = 2'b00,
		SLD_PH_OFF1 = 2'b01,
		SLD_PH_ON2  = 2'b10,
		SLD_PH_GAP  = 2'b11
	} sld_phase_t;
	typedef logic [24:0] sld_cnt_t;
endpackage : sld_pkg

/* File: rtl/sld_pat_if.sv */
// Pattern request and indicator level between selector and generator
`timescale 1ns/10ps
interface sld_pat_if;
	sld_pkg::sld_pat_t mode;
	logic              led;
	modport sel (output mode, input led);
	modport gen (input mode, output led);
endinterface : sld_pat_if

/* File: rtl/sld_pattern_gen.sv */
// Indicator waveform generator for one status indicator
`timescale 1ns/10ps
module sld_pattern_gen #(
	parameter sld_pkg::sld_cnt_t FLICKER_CYC = 25'h0F4240,
	parameter sld_pkg::sld_cnt_t BLINK_CYC   = 25'h3D0900,
	parameter sld_pkg::sld_cnt_t GAP_CYC     = 25'h1312D00
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pattern request
	sld_pat_if.gen   pat
);
	typedef struct packed {
		sld_pkg::sld_pat_t   mode;
		sld_pkg::sld_phase_t phase;
		sld_pkg::sld_cnt_t   cnt;
		logic                led;
	} sld_gen_state_t;

	sld_gen_state_t    st;
	sld_gen_state_t    next_st;
	sld_pkg::sld_cnt_t span;

	always_comb begin
		next_st = st;
		if (st.mode == sld_pkg::SLD_PAT_FLICKER)
			span = FLICKER_CYC;
		else if (st.phase == sld_pkg::SLD_PH_GAP)
			span = GAP_CYC;
		else
			span = BLINK_CYC;
		// A new request restarts at the first on period
		if (pat.mode != st.mode) begin
			next_st.mode  = pat.mode;
			next_st.phase = sld_pkg::SLD_PH_ON1;
			next_st.cnt   = '0;
		end else if (st.cnt == span - 25'h1) begin
			next_st.cnt = '0;
			unique case (st.phase)
				sld_pkg::SLD_PH_ON1: next_st.phase = sld_pkg::SLD_PH_OFF1;
				sld_pkg::SLD_PH_OFF1: next_st.phase = (st.mode == sld_pkg::SLD_PAT_BLINK2) ?
					sld_pkg::SLD_PH_ON2 : sld_pkg::SLD_PH_ON1;
				sld_pkg::SLD_PH_ON2: next_st.phase = sld_pkg::SLD_PH_GAP;
				sld_pkg::SLD_PH_GAP: next_st.phase = sld_pkg::SLD_PH_ON1;
			endcase
		end else begin
			next_st.cnt = st.cnt + 25'h1;
		end
		unique case (next_st.mode)
			sld_pkg::SLD_PAT_OFF: next_st.led = 1'b0;
			sld_pkg::SLD_PAT_ON: next_st.led = 1'b1;
			default: next_st.led = (next_st.phase == sld_pkg::SLD_PH_ON1) ||
				(next_st.phase == sld_pkg::SLD_PH_ON2);
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st <= '{mode: sld_pkg::SLD_PAT_OFF, phase: sld_pkg::SLD_PH_ON1, cnt: '0, led: 1'b0};
		else
			st <= next_st;
	end

	assign pat.led = st.led;
endmodule : sld_pattern_gen

/* File: rtl/sld_irq.sv */
// Sticky event status, mask and level interrupt
`timescale 1ns/10ps
`include "sld_regs.svh"
module sld_irq (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Events and software access
	input  wire logic [3:0] events,
	input  wire logic [3:0] clr,
	input  wire logic       mask_we,
	input  wire logic [3:0] mask_wdata,
	// State
	output logic      [3:0] status,
	output logic      [3:0] mask,
	output logic            irq
);
	typedef struct packed {
		logic [3:0] status;
		logic [3:0] mask;
		logic       irq;
	} sld_irq_state_t;

	sld_irq_state_t st;
	sld_irq_state_t next_st;

	always_comb begin
		next_st = st;
		// Set wins over a clear in the same cycle
		next_st.status = (st.status & ~clr) | events;
		if (mask_we)
			next_st.mask = mask_wdata;
		next_st.irq = |(next_st.status & next_st.mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st <= '{status: 4'h0, mask: `SLD_MASK_RST, irq: 1'b0};
		else
			st <= next_st;
	end

	assign status = st.status;
	assign mask   = st.mask;
	assign irq    = st.irq;
endmodule : sld_irq

/* File: rtl/status_led_pattern_driver.sv */
// Front-panel run and fault indicator driver with APB registers
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/10ps
`include "sld_regs.svh"
// Overview of operation
// - No power or failed: both dark
// - Operational and tested: run steady on
// - Watchdog expired: both steady on
// - Pre-operational: run single blink
// - Field power lost or short: fault flickers
// - Nonfatal error: fault single blink
// - Island bus stopped: fault double blink
// - Flicker is 50 ms on, 50 off
// - Single blink is 200 ms on, 200 off
// - Double blink: on, off, on again
// - Supply fault may arrive 15 ms late
// - Local field power fault shown immediately
module status_led_pattern_driver #(
	parameter int FLICKER_CYC = `SLD_FLICKER_MS * (`SLD_CLK_HZ / 1000),
	parameter int BLINK_CYC   = `SLD_BLINK_MS * (`SLD_CLK_HZ / 1000),
	parameter int GAP_CYC     = `SLD_GAP_MS * (`SLD_CLK_HZ / 1000)
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	// Module status conditions
	input  wire logic        logic_power_ok,
	input  wire logic        module_failed,
	input  wire logic        self_test_passed,
	input  wire logic        operational,
	input  wire logic        watchdog_expired,
	input  wire logic        preop_mode,
	input  wire logic        field_power_local_lost,
	input  wire logic        power_distribution_module_fault,
	input  wire logic        nonfatal_error,
	input  wire logic        island_bus_stopped,
	// Indicators
	output logic             run_led,
	output logic             fault_led,
	// Interrupt
	output logic             irq
);
	typedef struct packed {
		logic        lamp_test;
		logic [3:0]  prev_ev;
		logic        run_led;
		logic        fault_led;
		logic        ready;
		logic [31:0] rdata;
		logic        slverr;
	} sld_top_state_t;

	sld_top_state_t st;
	sld_top_state_t next_st;

	sld_pat_if run_pat ();
	sld_pat_if fault_pat ();

	logic       live;
	logic       pwr_fault;
	logic [3:0] ev_level;
	logic [3:0] ev_pulse;
	logic [3:0] int_clr;
	logic       mask_we;
	logic [3:0] int_status;
	logic [3:0] int_mask;
	logic       access;
	logic       commit;
	logic [2:0] wr_sel;
	logic [2:0] rd_sel;

	// Returns {hit, index}; low address bits are ignored
	function automatic logic [2:0] sld_reg_sel(input logic [7:0] addr);
		logic [7:0] word;
		word = {addr[7:2], 2'b00};
		if (word == `SLD_CTRL_OFS)
			sld_reg_sel = 3'b100;
		else if (word == `SLD_COND_OFS)
			sld_reg_sel = 3'b101;
		else if (word == `SLD_INT_STAT_OFS)
			sld_reg_sel = 3'b110;
		else if (word == `SLD_INT_MASK_OFS)
			sld_reg_sel = 3'b111;
		else
			sld_reg_sel = 3'b000;
	endfunction : sld_reg_sel

	sld_pattern_gen #(
		.FLICKER_CYC (sld_pkg::sld_cnt_t'(FLICKER_CYC)),
		.BLINK_CYC   (sld_pkg::sld_cnt_t'(BLINK_CYC)),
		.GAP_CYC     (sld_pkg::sld_cnt_t'(GAP_CYC))
	) u_run_gen (
		.pclk    (pclk),
		.presetn (presetn),
		.pat     (run_pat.gen)
	);

	sld_pattern_gen #(
		.FLICKER_CYC (sld_pkg::sld_cnt_t'(FLICKER_CYC)),
		.BLINK_CYC   (sld_pkg::sld_cnt_t'(BLINK_CYC)),
		.GAP_CYC     (sld_pkg::sld_cnt_t'(GAP_CYC))
	) u_fault_gen (
		.pclk    (pclk),
		.presetn (presetn),
		.pat     (fault_pat.gen)
	);

	sld_irq u_irq (
		.pclk       (pclk),
		.presetn    (presetn),
		.events     (ev_pulse),
		.clr        (int_clr),
		.mask_we    (mask_we),
		.mask_wdata (pwdata[3:0]),
		.status     (int_status),
		.mask       (int_mask),
		.irq        (irq)
	);

	// Condition qualification
	always_comb begin
		live = logic_power_ok & ~module_failed;
		// The supply fault is already late from its detector; no extra filter here
		pwr_fault = power_distribution_module_fault;
		// Local field loss bypasses any delay
		pwr_fault = pwr_fault | field_power_local_lost;
		ev_level = 4'h0;
		ev_level[`SLD_EV_WDOG] = watchdog_expired;
		ev_level[`SLD_EV_PWR]  = pwr_fault;
		ev_level[`SLD_EV_BUS]  = island_bus_stopped;
		ev_level[`SLD_EV_NFE]  = nonfatal_error;
		ev_pulse = ev_level & ~st.prev_ev;
	end

	// Run indicator selection
	always_comb begin
		if (!live)
			run_pat.mode = sld_pkg::SLD_PAT_OFF;
		else if (watchdog_expired)
			run_pat.mode = sld_pkg::SLD_PAT_ON;
		else if (preop_mode)
			run_pat.mode = sld_pkg::SLD_PAT_BLINK1;
		else if (self_test_passed && operational)
			run_pat.mode = sld_pkg::SLD_PAT_ON;
		else
			run_pat.mode = sld_pkg::SLD_PAT_OFF;
	end

	// Fault indicator selection, watchdog highest once live
	always_comb begin
		if (!live)
			fault_pat.mode = sld_pkg::SLD_PAT_OFF;
		else if (watchdog_expired)
			fault_pat.mode = sld_pkg::SLD_PAT_ON;
		else if (pwr_fault)
			fault_pat.mode = sld_pkg::SLD_PAT_FLICKER;
		else if (island_bus_stopped)
			fault_pat.mode = sld_pkg::SLD_PAT_BLINK2;
		else if (nonfatal_error)
			fault_pat.mode = sld_pkg::SLD_PAT_BLINK1;
		else
			fault_pat.mode = sld_pkg::SLD_PAT_OFF;
	end

	// APB handshake: one wait state, writes land when pready is seen high
	always_comb begin
		access  = psel & penable;
		commit  = access & st.ready;
		wr_sel  = sld_reg_sel(paddr);
		rd_sel  = sld_reg_sel(paddr);
		int_clr = 4'h0;
		mask_we = 1'b0;
		if (commit && pwrite && wr_sel == 3'b110)
			int_clr = pwdata[3:0];
		if (commit && pwrite && wr_sel == 3'b111)
			mask_we = 1'b1;
	end

	always_comb begin
		next_st = st;
		next_st.prev_ev = ev_level;
		next_st.ready   = access & ~st.ready;
		if (access && !st.ready) begin
			next_st.slverr = ~rd_sel[2];
			next_st.rdata  = 32'h0000_0000;
			if (!pwrite) begin
				unique case (rd_sel)
					3'b100: next_st.rdata[`SLD_CTRL_TEST_BIT] = st.lamp_test;
					3'b101: begin
						next_st.rdata[9:0] = {island_bus_stopped, nonfatal_error,
							power_distribution_module_fault, field_power_local_lost,
							preop_mode, watchdog_expired, operational,
							self_test_passed, module_failed, logic_power_ok};
						next_st.rdata[`SLD_COND_RUN_BIT]   = st.run_led;
						next_st.rdata[`SLD_COND_FAULT_BIT] = st.fault_led;
					end
					3'b110: next_st.rdata[3:0] = int_status;
					3'b111: next_st.rdata[3:0] = int_mask;
					default: next_st.rdata = 32'h0000_0000;
				endcase
			end
		end else if (!access) begin
			next_st.slverr = 1'b0;
		end
		if (commit && pwrite && wr_sel == 3'b100)
			next_st.lamp_test = pwdata[`SLD_CTRL_TEST_BIT];
		// Lamp test is held off without power so a dead module stays dark
		next_st.run_led   = live & (st.lamp_test | run_pat.led);
		next_st.fault_led = live & (st.lamp_test | fault_pat.led);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st <= '{lamp_test: `SLD_CTRL_RST, prev_ev: 4'h0, run_led: 1'b0,
				fault_led: 1'b0, ready: 1'b0, rdata: 32'h0000_0000, slverr: 1'b0};
		else
			st <= next_st;
	end

	assign pready    = st.ready;
	assign prdata    = st.rdata;
	assign pslverr   = st.slverr;
	assign run_led   = st.run_led;
	assign fault_led = st.fault_led;
endmodule : status_led_pattern_driver

/* File: verif/sld_asserts.sv */
// Pattern timing and priority checks on the indicator driver ports
`timescale 1ns/10ps
module sld_asserts #(
	parameter int FLICKER_CYC = 5,
	parameter int BLINK_CYC   = 20,
	parameter int GAP_CYC     = 100
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Conditions
	input wire logic logic_power_ok,
	input wire logic module_failed,
	input wire logic self_test_passed,
	input wire logic operational,
	input wire logic watchdog_expired,
	input wire logic preop_mode,
	input wire logic field_power_local_lost,
	input wire logic power_distribution_module_fault,
	input wire logic nonfatal_error,
	input wire logic island_bus_stopped,
	// Indicators
	input wire logic run_led,
	input wire logic fault_led
);
	int   r_hi;
	int   f_hi;
	int   f_lo;
	logic live;
	logic flk;
	logic bus2;
	logic nfe1;
	assign live = logic_power_ok & ~module_failed & ~watchdog_expired;
	assign flk  = live & (field_power_local_lost | power_distribution_module_fault);
	assign bus2 = live & ~field_power_local_lost & ~power_distribution_module_fault
		& island_bus_stopped;
	assign nfe1 = bus2 == 1'b0 && flk == 1'b0 && live && !island_bus_stopped && nonfatal_error;
	// Run lengths of lit and dark spans
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_hi <= 0;
			f_hi <= 0;
			f_lo <= 0;
		end else begin
			r_hi <= run_led ? r_hi + 1 : 0;
			f_hi <= fault_led ? f_hi + 1 : 0;
			f_lo <= fault_led ? 0 : f_lo + 1;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_dark_unpowered: assert property (!logic_power_ok [*4] |-> !run_led && !fault_led)
		else $error("lit without power");
	a_run_steady: assert property ((live & self_test_passed & operational & ~preop_mode)
		[*4] |-> run_led) else $error("run not steady");
	a_wdog_both: assert property ((logic_power_ok & ~module_failed & watchdog_expired) [*4]
		|-> run_led && fault_led) else $error("watchdog not both on");
	a_preop_blink: assert property ((live & preop_mode) [*8] ##0 $fell(run_led)
		|-> r_hi == BLINK_CYC) else $error("preop blink length");
	a_flicker_on: assert property (flk [*8] ##0 $fell(fault_led) |-> f_hi == FLICKER_CYC)
		else $error("flicker on length");
	a_flicker_off: assert property (flk [*8] ##0 $rose(fault_led) |-> f_lo == FLICKER_CYC)
		else $error("flicker off length");
	a_nfe_blink: assert property (nfe1 [*8] ##0 $fell(fault_led) |-> f_hi == BLINK_CYC)
		else $error("nonfatal blink length");
	a_bus_on: assert property (bus2 [*8] ##0 $fell(fault_led) |-> f_hi == BLINK_CYC)
		else $error("double blink on length");
	a_bus_gap: assert property (bus2 [*8] ##0 $rose(fault_led)
		|-> f_lo == BLINK_CYC || f_lo == GAP_CYC) else $error("double blink off length");
endmodule : sld_asserts

bind status_led_pattern_driver sld_asserts #(.FLICKER_CYC(FLICKER_CYC), .BLINK_CYC(BLINK_CYC),
	.GAP_CYC(GAP_CYC)) u_chk (.pclk(pclk), .presetn(presetn), .logic_power_ok(logic_power_ok),
	.module_failed(module_failed), .self_test_passed(self_test_passed),
	.operational(operational), .watchdog_expired(watchdog_expired), .preop_mode(preop_mode),
	.field_power_local_lost(field_power_local_lost),
	.power_distribution_module_fault(power_distribution_module_fault),
	.nonfatal_error(nonfatal_error), .island_bus_stopped(island_bus_stopped),
	.run_led(run_led), .fault_led(fault_led));

/* File: verif/sld_led_model.sv */
// Front-panel lamps: tallies lit cycles of each indicator
`timescale 1ns/10ps
module sld_led_model (
	// Clock and drives
	input wire logic pclk,
	input wire logic run_led,
	input wire logic fault_led,
	// Lit-cycle tallies
	output int       run_lit,
	output int       fault_lit
);
	initial run_lit = 0;
	initial fault_lit = 0;
	// Unknown drive counts as dark
	always @(posedge pclk) begin
		run_lit <= run_lit + int'(run_led === 1'b1);
		fault_lit <= fault_lit + int'(fault_led === 1'b1);
	end
endmodule : sld_led_model

/* File: verif/test_status_led_pattern_driver.sv */
// Self-checking bench for the status indicator driver
`timescale 1ns/10ps
module test_status_led_pattern_driver;
	logic        pclk;
	logic        presetn;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [9:0]  cond;
	logic        run_led;
	logic        fault_led;
	logic        irq;
	logic [31:0] q;
	logic        e;
	int          run_lit;
	int          fault_lit;
	int          fails;
	int          n_tests;

	status_led_pattern_driver #(.FLICKER_CYC(5), .BLINK_CYC(20), .GAP_CYC(100)) dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.logic_power_ok(cond[0]), .module_failed(cond[1]), .self_test_passed(cond[2]),
		.operational(cond[3]), .watchdog_expired(cond[4]), .preop_mode(cond[5]),
		.field_power_local_lost(cond[6]), .power_distribution_module_fault(cond[7]),
		.nonfatal_error(cond[8]), .island_bus_stopped(cond[9]),
		.run_led(run_led), .fault_led(fault_led), .irq(irq));
	sld_led_model lamps (.pclk(pclk), .run_led(run_led), .fault_led(fault_led),
		.run_lit(run_lit), .fault_lit(fault_lit));

	always #25 pclk = ~pclk;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			fails++;
		end
	endtask : chk

	task automatic report_and_stop;
		if (fails == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// No cycle limit here; a hung slave is ended by the watchdog
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		chk("wait states", 2, n);
	endtask : apb

	// Dark step first so no lit span runs into the next pattern
	task automatic set(input logic [9:0] v);
		cond <= 10'h001;
		repeat (4) @(posedge pclk);
		cond <= v;
		repeat (3) @(posedge pclk);
	endtask : set

	task automatic lit(input int n, input int er, input int ef);
		int r0;
		int f0;
		r0 = run_lit;
		f0 = fault_lit;
		repeat (n) @(posedge pclk);
		chk("run lit", er, run_lit - r0);
		chk("fault lit", ef, fault_lit - f0);
	endtask : lit

	task automatic t_regs;
		apb(0, 8'h00, 0);
		chk("ctrl", 0, q);
		apb(0, 8'h0C, 0);
		chk("mask", 0, q);
		apb(0, 8'h10, 0);
		chk("unmapped", 1, e);
		apb(1, 8'h04, 32'hFFFFFFFF);
		chk("cond write", 0, e);
		set(10'h00D);
		apb(0, 8'h04, 0);
		chk("cond", 32'h0001000D, q);
		set(10'h001);
		apb(1, 8'h00, 1);
		// Lamps light one edge after the write lands
		@(posedge pclk);
		lit(20, 20, 20);
		apb(1, 8'h00, 0);
	endtask : t_regs

	task automatic t_irq;
		set(10'h011);
		apb(0, 8'h08, 0);
		chk("stat", 1, q);
		chk("irq masked", 0, irq);
		apb(1, 8'h0C, 32'hF);
		repeat (2) @(posedge pclk);
		chk("irq", 1, irq);
		apb(1, 8'h08, 1);
		repeat (2) @(posedge pclk);
		chk("irq cleared", 0, irq);
		set(10'h381);
		apb(0, 8'h08, 0);
		chk("stat", 32'hE, q);
		apb(1, 8'h08, 32'hF);
		apb(0, 8'h08, 0);
		chk("stat cleared", 0, q);
	endtask : t_irq

	task automatic t_pat;
		logic [9:0] v[10] = '{10'h000, 10'h003, 10'h00D, 10'h3FD, 10'h02D,
			10'h081, 10'h041, 10'h3C1, 10'h301, 10'h101};
		int w[10] = '{40, 40, 40, 40, 160, 100, 100, 100, 160, 160};
		int r[10] = '{0, 0, 40, 40, 80, 0, 0, 0, 0, 0};
		int f[10] = '{0, 0, 0, 40, 0, 50, 50, 50, 40, 80};
		for (int i = 0; i < 10; i++) begin
			set(v[i]);
			lit(w[i], r[i], f[i]);
		end
	endtask : t_pat

	initial begin
		pclk = 0;
		presetn = 0;
		{paddr, psel, penable, pwrite, pwdata, cond} = '0;
		fails = 0;
		n_tests = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_irq;
		t_pat;
		report_and_stop;
	end

	initial begin
		repeat (5000) @(posedge pclk);
		fails++;
		report_and_stop;
	end
endmodule : test_status_led_pattern_driver
